// ==== design/wdog_pkg.sv ====
// package of constants for the watchdog with reset-cause flags
//
// Overview of operation
// - counter advances only on low-speed rc clock ticks, one count per tick with no prescaler
// - period select codes 000..111 give 2^8,10,12,14,15,16,17,18 tick timeouts
// - enable key 01010 runs the watchdog, key 10101 stops it
// - any other key value forces a full device reset after the soft reset delay
// - a key-corruption reset sets the key reset flag to one
// - only hardware sets the key reset flag; software may only clear it
// - after power-up the key holds the enable code and the period select holds 011
// - overflow in normal run resets the device and sets the timeout status flag
// - overflow in sleep or idle sets timeout flag, resets only pc and stack pointer
// - counter cleared by bad key, clear instruction, halt, or low reset pin if selected
// - upper four bits of the reset flag register read as zero
// - power-on reset loads the program counter with zero
// - power-on reset sets all port data and direction registers to all ones
// - halt clears the counter; it keeps counting only while enabled
// - timeout reset in normal run acts as pin reset plus the timeout flag
package wdog_pkg;
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_FLAGS = 2'h1;
    localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
    localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;
    localparam logic [4:0] KEY_ENABLE = 5'h0a;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [7:0] CTRL_RESET = 8'h53;
    localparam int KEY_LSB = 3;
    localparam int FLAG_KEY_BIT = 0;
    localparam int CNT_W = 18;
    localparam int PORT_W = 8;
    localparam int PC_W = 13;
    localparam int SP_W = 3;
    localparam logic [PORT_W-1:0] PORT_POR = 8'hff;
    // soft reset delay in microseconds and derived cycle count at 25 MHz
    localparam int SOFT_RESET_DELAY_US = 32;
    localparam int CLK_MHZ = 25;
    localparam int SOFT_RESET_CYC = SOFT_RESET_DELAY_US * CLK_MHZ;
    localparam logic [9:0] SOFT_RESET_CNT = 10'(SOFT_RESET_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
    // irq status bit positions
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_KEY = 1;
endpackage

// ==== design/wdog_sync.sv ====
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module wdog_sync (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic d_i, // asynchronous level
    output logic q_o // synchronised level
);
    logic meta_r;
    // first stage read only by second stage
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ==== design/wdog_tick.sv ====
// rising edge detector on the synchronised low-speed clock
`timescale 1ns/100ps
module wdog_tick (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic lvl_i, // synchronised level
    output logic tick_o // one-cycle pulse on rise
);
    logic prev_r;
    // remember last level and flag a rise
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_r <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            prev_r <= lvl_i;
            tick_o <= lvl_i & ~prev_r;
        end
    end
endmodule

// ==== design/wdog_top.sv ====
// watchdog timer with key-protected control and reset-cause flags
`timescale 1ns/100ps
module wdog_top (
    input wire logic clk_sys_i, // system clock 25 MHz
    input wire logic rstn_i, // power-on reset, active low
    input wire logic low_speed_rc_clock_i, // low-speed rc clock, asynchronous
    input wire logic external_reset_pin_n_i, // external reset pin, active low, asynchronous
    input wire logic reset_pin_select_i, // reset pin function selected
    input wire logic clear_watchdog_instruction_i, // clear instruction executed, pulse
    input wire logic halt_instruction_i, // halt instruction executed, pulse
    input wire logic power_down_i, // device in sleep or idle
    input wire logic [1:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, one cycle after rd_i
    output logic device_reset_o, // full device reset pulse
    output logic pc_sp_reset_o, // pc and stack pointer clear pulse
    output logic timeout_status_flag_o, // timeout status flag
    output logic [wdog_pkg::PC_W-1:0] prog_counter_o, // program counter reset value holder
    output logic [wdog_pkg::PORT_W-1:0] port_data_o, // port data register
    output logic [wdog_pkg::PORT_W-1:0] port_dir_o, // port direction register
    output logic irq_o // interrupt, level
);
    import wdog_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic lsc_sync, pin_low_sync, lsc_tick;
    logic [4:0] wdog_enable_key_r;
    logic [2:0] timeout_period_select_r;
    logic wdog_key_reset_flag_r;
    logic [CNT_W-1:0] cnt_r;
    logic [9:0] delay_r;
    logic delay_run_r;
    logic [1:0] irq_stat_r, irq_mask_r;
    logic key_bad, overflow, pin_clear, cnt_clear, running, key_fire;

    wdog_sync u_sync_lsc (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .d_i(low_speed_rc_clock_i),
        .q_o(lsc_sync)
    );
    wdog_sync u_sync_pin (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .d_i(~external_reset_pin_n_i), // inverted so the reset value reads as pin released
        .q_o(pin_low_sync)
    );
    wdog_tick u_tick (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .lvl_i(lsc_sync),
        .tick_o(lsc_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // map period select code to the overflow bit position
    function automatic logic [4:0] sel_bit(input logic [2:0] sel);
        logic [4:0] b;
        b = 5'h08;
        case (sel)
            3'h0: b = 5'h08;
            3'h1: b = 5'h0a;
            3'h2: b = 5'h0c;
            3'h3: b = 5'h0e;
            3'h4: b = 5'h0f;
            3'h5: b = 5'h10;
            3'h6: b = 5'h11;
            3'h7: b = 5'h12;
            default: b = 5'h08;
        endcase
        return b;
    endfunction

    // key classification and counter controls
    assign key_bad = (wdog_enable_key_r != KEY_ENABLE) && (wdog_enable_key_r != KEY_DISABLE);
    assign running = (wdog_enable_key_r == KEY_ENABLE);
    assign pin_clear = reset_pin_select_i & pin_low_sync;
    assign cnt_clear = key_bad | clear_watchdog_instruction_i | halt_instruction_i | pin_clear;
    // selected bit index 18 means the full count wrapped into bit 18
    assign overflow = running && lsc_tick && ((sel_bit(timeout_period_select_r) == 5'h12) ?
                      (cnt_r == {CNT_W{1'b1}}) :
                      (cnt_r[sel_bit(timeout_period_select_r)] == 1'b0 &&
                       cnt_r[sel_bit(timeout_period_select_r) - 5'h01 -: 1] == 1'b1 &&
                       (cnt_r & ((CNT_ONE << sel_bit(timeout_period_select_r)) - CNT_ONE)) ==
                       ((CNT_ONE << sel_bit(timeout_period_select_r)) - CNT_ONE)));
    assign key_fire = delay_run_r && (delay_r == 10'h001);

    ////////////////////////////////////////////////////////////////////////
    // counter on low-speed ticks, cleared by the four clear events
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= CNT_ZERO;
        end else if (cnt_clear || overflow || !running) begin
            cnt_r <= CNT_ZERO;
        end else if (lsc_tick) begin
            cnt_r <= cnt_r + CNT_ONE;
        end
    end

    // control register, key and period select
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdog_enable_key_r <= CTRL_RESET[7:KEY_LSB];
            timeout_period_select_r <= CTRL_RESET[KEY_LSB-1:0];
        end else if (key_fire || device_reset_o) begin
            wdog_enable_key_r <= CTRL_RESET[7:KEY_LSB];
            timeout_period_select_r <= CTRL_RESET[KEY_LSB-1:0];
        end else if (wr_i && addr_i == ADDR_CTRL) begin
            wdog_enable_key_r <= wdata_i[7:KEY_LSB];
            timeout_period_select_r <= wdata_i[KEY_LSB-1:0];
        end
    end

    // soft reset delay after a corrupted key
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            delay_r <= SOFT_RESET_CNT;
            delay_run_r <= 1'b0;
        end else if (key_fire) begin
            delay_run_r <= 1'b0;
            delay_r <= SOFT_RESET_CNT;
        end else if (key_bad && !delay_run_r) begin
            delay_run_r <= 1'b1;
            delay_r <= SOFT_RESET_CNT;
        end else if (delay_run_r) begin
            delay_r <= delay_r - 10'h001;
        end
    end

    // key reset flag: hardware sets, software writes zero to clear, set wins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdog_key_reset_flag_r <= 1'b0;
        end else if (key_fire) begin
            wdog_key_reset_flag_r <= 1'b1;
        end else if (wr_i && addr_i == ADDR_FLAGS && !wdata_i[FLAG_KEY_BIT]) begin
            wdog_key_reset_flag_r <= 1'b0;
        end
    end

    // reset outputs and timeout status
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            device_reset_o <= 1'b0;
            pc_sp_reset_o <= 1'b0;
            timeout_status_flag_o <= 1'b0;
        end else begin
            device_reset_o <= key_fire | (overflow & ~power_down_i);
            pc_sp_reset_o <= overflow & power_down_i;
            if (overflow) begin
                timeout_status_flag_o <= 1'b1;
            end else if (halt_instruction_i || clear_watchdog_instruction_i || key_fire) begin
                timeout_status_flag_o <= 1'b0;
            end
        end
    end

    // power-on state of program counter and ports
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prog_counter_o <= '0;
            port_data_o <= PORT_POR;
            port_dir_o <= PORT_POR;
        end else if (device_reset_o || pc_sp_reset_o) begin
            prog_counter_o <= '0;
            if (device_reset_o) begin
                port_data_o <= PORT_POR;
                port_dir_o <= PORT_POR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, set wins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_r[IRQ_TIMEOUT] <= overflow |
                (irq_stat_r[IRQ_TIMEOUT] & ~(wr_i && addr_i == ADDR_IRQ_STAT && wdata_i[IRQ_TIMEOUT]));
            irq_stat_r[IRQ_KEY] <= key_fire |
                (irq_stat_r[IRQ_KEY] & ~(wr_i && addr_i == ADDR_IRQ_STAT && wdata_i[IRQ_KEY]));
            if (wr_i && addr_i == ADDR_IRQ_MASK) begin
                irq_mask_r <= wdata_i[1:0];
            end
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: rdata_o <= {wdog_enable_key_r, timeout_period_select_r};
                ADDR_FLAGS: rdata_o <= {7'h00, wdog_key_reset_flag_r};
                ADDR_IRQ_STAT: rdata_o <= {6'h00, irq_stat_r};
                ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask_r};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_key_delay;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(delay_run_r) |-> !device_reset_o [*8];
    endproperty
    a_key_delay: assert property (p_key_delay) else $error("reset too early after bad key");

    property p_flag_set;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        key_fire |=> wdog_key_reset_flag_r && device_reset_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("key flag not set");

    property p_flag_sw;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !key_fire && !wdog_key_reset_flag_r |=> !wdog_key_reset_flag_r;
    endproperty
    a_flag_sw: assert property (p_flag_sw) else $error("key flag set by software");

    property p_normal_ovf;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        overflow && !power_down_i |=> device_reset_o && timeout_status_flag_o && !pc_sp_reset_o;
    endproperty
    a_normal_ovf: assert property (p_normal_ovf) else $error("normal overflow wrong");

    property p_sleep_ovf;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        overflow && power_down_i |=> pc_sp_reset_o && !device_reset_o ##1 prog_counter_o == '0;
    endproperty
    a_sleep_ovf: assert property (p_sleep_ovf) else $error("sleep overflow wrong");

    property p_clear;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        clear_watchdog_instruction_i || halt_instruction_i |=> cnt_r == CNT_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");

    property p_stopped;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        wdog_enable_key_r == KEY_DISABLE |=> cnt_r == CNT_ZERO && !overflow;
    endproperty
    a_stopped: assert property (p_stopped) else $error("disabled watchdog counts");

    property p_upper_zero;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rd_i && addr_i == ADDR_FLAGS |=> rdata_o[7:4] == 4'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved bits not zero");

    // clearing, reload and sticky-flag checks
    property p_pin_clear;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        reset_pin_select_i && pin_low_sync |=> cnt_r == CNT_ZERO;
    endproperty
    a_pin_clear: assert property (p_pin_clear) else $error("pin low did not clear counter");

    property p_key_clear;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        key_bad |=> cnt_r == CNT_ZERO;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("bad key did not clear counter");

    property p_tick_only;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !lsc_tick |=> $stable(cnt_r) || cnt_r == CNT_ZERO;
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("counter moved without a tick");

    property p_pcsp_pulse;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        pc_sp_reset_o |=> !pc_sp_reset_o;
    endproperty
    a_pcsp_pulse: assert property (p_pcsp_pulse) else $error("pc clear longer than one cycle");

    property p_reset_reload;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        device_reset_o |-> ##2 {wdog_enable_key_r, timeout_period_select_r} == CTRL_RESET;
    endproperty
    a_reset_reload: assert property (p_reset_reload) else $error("control not reloaded");

    property p_ports;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        device_reset_o |=> port_data_o == PORT_POR && port_dir_o == PORT_POR;
    endproperty
    a_ports: assert property (p_ports) else $error("ports not set to inputs");

    property p_flag_sticky;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        wdog_key_reset_flag_r && !(wr_i && addr_i == ADDR_FLAGS) |=> wdog_key_reset_flag_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("key flag cleared by hardware");

    c_normal_ovf: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) overflow && !power_down_i);
    c_sleep_ovf: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) overflow && power_down_i);
    c_key_fire: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) key_fire);
    c_pin_clear: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) pin_clear);
endmodule

// ==== tb/wdog_top_tb.sv ====
// self-checking testbench for the watchdog with reset-cause flags
`timescale 1ns/100ps
module wdog_top_tb;
    import wdog_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] ls_div = 3'h0;
    logic pin_n = 1'b1;
    logic pin_sel = 1'b0;
    logic clr_ins = 1'b0;
    logic halt_ins = 1'b0;
    logic pdown = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic dev_rst;
    logic pcsp_rst;
    logic to_flag;
    logic irq;
    logic [PC_W-1:0] pc;
    logic [PORT_W-1:0] pdata;
    logic [PORT_W-1:0] pdir;
    logic [7:0] got;
    int fails = 0;
    int samples_checked = 0;
    int n_dev = 0;
    int base;
    int used;
////////////////////////////////////////
    wdog_top dut (
        .clk_sys_i(clk_sys), .rstn_i(rstn), .low_speed_rc_clock_i(ls_div[2]),
        .external_reset_pin_n_i(pin_n), .reset_pin_select_i(pin_sel),
        .clear_watchdog_instruction_i(clr_ins), .halt_instruction_i(halt_ins),
        .power_down_i(pdown), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .device_reset_o(dev_rst), .pc_sp_reset_o(pcsp_rst),
        .timeout_status_flag_o(to_flag), .prog_counter_o(pc), .port_data_o(pdata),
        .port_dir_o(pdir), .irq_o(irq)
    );
    // 25 MHz system clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // low-speed clock scaled to one tick per 8 cycles to keep the run short
    always @(posedge clk_sys) begin
        ls_div <= ls_div + 3'h1;
    end
    // count full device reset pulses
    always @(posedge clk_sys) begin
        if (dev_rst === 1'b1) n_dev <= n_dev + 1;
    end
////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_cnt(input string what, input int exp, input int seen);
        samples_checked++;
        if (seen != exp) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // one-cycle instruction pulse: 0 clear, 1 halt
    task automatic pulse_in(input int which);
        @(posedge clk_sys);
        if (which == 0) clr_ins <= 1'b1;
        else halt_ins <= 1'b1;
        @(posedge clk_sys);
        clr_ins <= 1'b0;
        halt_ins <= 1'b0;
    endtask
    task automatic run_ticks(input int n);
        repeat (n * 8) @(posedge clk_sys);
    endtask
    // bounded wait for a full reset (pd 0) or a pc/sp clear (pd 1)
    task automatic wait_rst(input logic pd, input int maxc);
        used = 0;
        do begin
            @(posedge clk_sys);
            #1;
            used++;
        end while (((pd ? pcsp_rst : dev_rst) !== 1'b1) && used < maxc);
        if ((pd ? pcsp_rst : dev_rst) !== 1'b1) begin
            fails++;
            $display("[FAIL] reset pulse expected 1 seen none");
            final_report();
        end
    endtask
    function automatic int ovf_log2(input int s);
        return (s < 4) ? 8 + 2 * s : 11 + s;
    endfunction
////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        chk_val("pc", 16'h0000, {3'h0, pc});
        chk_val("port data", 16'h00ff, {8'h00, pdata});
        chk_val("port dir", 16'h00ff, {8'h00, pdir});
        rd_reg(ADDR_CTRL, got);
        chk_val("control", {8'h00, CTRL_RESET}, {8'h00, got});
        rd_reg(ADDR_FLAGS, got);
        chk_val("flags", 16'h0000, {8'h00, got});
        // every long period select code is stored and read back
        for (int s = 3; s < 8; s++) begin
            wr_reg(ADDR_CTRL, {KEY_ENABLE, 3'(s)});
            rd_reg(ADDR_CTRL, got);
            chk_val("period select", {8'h00, KEY_ENABLE, 3'(s)}, {8'h00, got});
        end
        $display("test power-on done");
        // stopped watchdog never overflows
        wr_reg(ADDR_CTRL, {KEY_DISABLE, 3'h0});
        run_ticks(300);
        chk_cnt("resets while stopped", 0, n_dev);
        $display("test disable done");
        // no overflow before the selected number of ticks minus 6, overflow within 12 ticks after that, codes 0 to 2
        for (int s = 0; s < 3; s++) begin
            wr_reg(ADDR_CTRL, {KEY_ENABLE, 3'(s)});
            pulse_in(0);
            base = n_dev;
            run_ticks((1 << ovf_log2(s)) - 6);
            chk_cnt("early overflow", base, n_dev);
            wait_rst(1'b0, 12 * 8);
            chk_val("timeout flag", 16'h0001, {15'h0, to_flag});
            rd_reg(ADDR_CTRL, got);
            chk_val("control after timeout", {8'h00, CTRL_RESET}, {8'h00, got});
            chk_val("irq masked", 16'h0000, {15'h0, irq});
        end
        $display("test overflow done");
        // clear, halt and pin keep it alive
        wr_reg(ADDR_CTRL, {KEY_ENABLE, 3'h0});
        base = n_dev;
        repeat (3) begin
            run_ticks(200);
            pulse_in(0);
        end
        chk_val("timeout flag cleared", 16'h0000, {15'h0, to_flag});
        run_ticks(200);
        pulse_in(1);
        run_ticks(200);
        @(posedge clk_sys);
        pin_sel <= 1'b1;
        pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        pin_n <= 1'b1;
        pin_sel <= 1'b0;
        run_ticks(200);
        chk_cnt("resets while serviced", base, n_dev);
        $display("test service done");
        // overflow in power-down clears only pc and stack pointer
        @(posedge clk_sys);
        pdown <= 1'b1;
        wait_rst(1'b1, 100 * 8);
        chk_cnt("full reset in power-down", base, n_dev);
        chk_val("timeout flag pd", 16'h0001, {15'h0, to_flag});
        rd_reg(ADDR_CTRL, got);
        chk_val("control kept", {8'h00, KEY_ENABLE, 3'h0}, {8'h00, got});
        @(posedge clk_sys);
        pdown <= 1'b0;
        $display("test power-down done");
        // corrupted key forces a delayed reset and sets the sticky flag
        wr_reg(ADDR_IRQ_MASK, 8'h02);
        wr_reg(ADDR_CTRL, 8'h00);
        wait_rst(1'b0, SOFT_RESET_CYC + 20);
        chk_cnt("key delay in window", 1, int'(used >= SOFT_RESET_CYC - 2 && used <= SOFT_RESET_CYC + 6));
        rd_reg(ADDR_FLAGS, got);
        chk_val("key flag", 16'h0001, {8'h00, got});
        rd_reg(ADDR_CTRL, got);
        chk_val("control reload", {8'h00, CTRL_RESET}, {8'h00, got});
        chk_val("irq raised", 16'h0001, {15'h0, irq});
        rd_reg(ADDR_IRQ_STAT, got);
        chk_val("irq status key", 16'h0001, {15'h0, got[IRQ_KEY]});
        wr_reg(ADDR_IRQ_STAT, 8'h03);
        repeat (2) @(posedge clk_sys);
        #1;
        chk_val("irq cleared", 16'h0000, {15'h0, irq});
        wr_reg(ADDR_FLAGS, 8'h00);
        rd_reg(ADDR_FLAGS, got);
        chk_val("flag cleared", 16'h0000, {8'h00, got});
        wr_reg(ADDR_FLAGS, 8'hff);
        rd_reg(ADDR_FLAGS, got);
        chk_val("flag not set by write", 16'h0000, {8'h00, got});
        $display("test key corruption done");
        final_report();
    end
endmodule
